// [rtl/sdmc_defines.svh]
// Constants of the split direct-mapped cache: geometry, buffer and encodings.
// Assumes it is included by the package and the design files by bare name.
`ifndef SDMC_DEFINES_SVH
`define SDMC_DEFINES_SVH

`define SDMC_ADDR_W      32
`define SDMC_WORD_W      32
`define SDMC_BE_W        4
`define SDMC_BE_FULL     4'hF
`define SDMC_LINE_WORDS  4
`define SDMC_WOFF_W      2
`define SDMC_LINE_LSB    4
`define SDMC_WORD_LSB    2
`define SDMC_WB_DEPTH    4
`define SDMC_WB_PTR_W    2
`define SDMC_I_LINES_DEF 64
`define SDMC_D_WORDS_DEF 512

`endif

// [rtl/sdmc_pkg.sv]
// Types shared by the cache controller and its write buffer.
// Assumes sdmc_defines.svh is on the include path.
`include "sdmc_defines.svh"

package sdmc_pkg;

  // One data-side request from the core
  typedef struct packed {
    logic                     valid;
    logic                     write;
    logic                     cacheable;
    logic [`SDMC_BE_W-1:0]    be;
    logic [`SDMC_ADDR_W-1:0]  addr;
    logic [`SDMC_WORD_W-1:0]  wdata;
  } sdmc_dreq_t;

  // Read request toward the bus interface unit
  typedef struct packed {
    logic                     req;
    logic                     block;
    logic [`SDMC_ADDR_W-1:0]  addr;
  } sdmc_rdreq_t;

  // One pending store in the write buffer
  typedef struct packed {
    logic [`SDMC_ADDR_W-1:0]  addr;
    logic [`SDMC_WORD_W-1:0]  data;
    logic [`SDMC_BE_W-1:0]    be;
  } sdmc_wbent_t;

  // Controller states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_DWAIT = 3'h1,
    ST_DREAD = 3'h2,
    ST_IREAD = 3'h3,
    ST_FIX   = 3'h4
  } sdmc_state_t;

endpackage

// [rtl/sdmc_wbuf.sv]
// Four-entry store FIFO between the data cache and the bus interface unit.
// Assumes the drain side runs on the same clock and may stall at will.
`timescale 1ns/1ps
`include "sdmc_defines.svh"

module sdmc_wbuf
  import sdmc_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         inValid,
  input  wire sdmc_wbent_t  inEnt,
  output logic              inReady,
  // Drain side
  output logic              outValid,
  output sdmc_wbent_t       outEnt,
  input  wire logic         outReady,
  // Status
  output logic              empty
);

  sdmc_wbent_t                fifo [`SDMC_WB_DEPTH];
  logic [`SDMC_WB_PTR_W-1:0]  wrPtr_r;
  logic [`SDMC_WB_PTR_W-1:0]  rdPtr_r;
  logic [`SDMC_WB_PTR_W:0]    count_r;
  logic                       push;
  logic                       pop;

  // Address and data captured in one cycle; drained strictly in order
  assign inReady  = (count_r != 3'(`SDMC_WB_DEPTH));
  assign outValid = (count_r != 3'h0);
  assign empty    = (count_r == 3'h0);
  assign outEnt   = fifo[rdPtr_r];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Storage needs no reset; only the pointers define what is live
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      fifo[wrPtr_r] <= inEnt;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wrPtr_r <= 2'h0;
      rdPtr_r <= 2'h0;
      count_r <= 3'h0;
    end
    else
    begin
      if (push)
      begin
        wrPtr_r <= wrPtr_r + 2'h1;
      end
      if (pop)
      begin
        rdPtr_r <= rdPtr_r + 2'h1;
      end
      count_r <= count_r + {2'h0, push} - {2'h0, pop};
    end
  end

endmodule

// [rtl/sdmc_cache.sv]
// Split instruction and data caches, direct-mapped and physically addressed.
// Assumes core and bus interface unit share clk; addresses are already physical.
`timescale 1ns/1ps
`include "sdmc_defines.svh"

module sdmc_cache
  import sdmc_pkg::*;
#(
  parameter int I_LINES = `SDMC_I_LINES_DEF,
  parameter int D_WORDS = `SDMC_D_WORDS_DEF
)(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Instruction side of the core
  input  wire logic         iReq,
  input  wire logic [31:0]  iAddr,
  input  wire logic         iCacheable,
  input  wire logic         iStreamStop,
  output logic              iValid,
  output logic [31:0]       iData,
  // Data side of the core
  input  wire sdmc_dreq_t   dReq,
  output logic              dValid,
  output logic [31:0]       dRdata,
  output logic              coreStall,
  // System option
  input  wire logic         dBlockRefill,
  // Read path from the bus interface unit
  output sdmc_rdreq_t       memRd,
  input  wire logic         memRdValid,
  input  wire logic [31:0]  memRdData,
  input  wire logic         memRdLast,
  // Store path to the bus interface unit
  output logic              wbValid,
  output sdmc_wbent_t       wbOut,
  input  wire logic         wbReady
);

  localparam int IIW = $clog2(I_LINES);
  localparam int DIW = $clog2(D_WORDS);
  localparam int ITW = `SDMC_ADDR_W - IIW - `SDMC_LINE_LSB;
  localparam int DTW = `SDMC_ADDR_W - DIW - `SDMC_WORD_LSB;

  // Separate storage for each cache; every word is a full 32 bits
  logic [31:0]     iMem  [I_LINES*`SDMC_LINE_WORDS];
  logic [ITW-1:0]  iTags [I_LINES];
  logic [31:0]     dMem  [D_WORDS];
  logic [DTW-1:0]  dTags [D_WORDS];
  logic [I_LINES-1:0]  iLineOk_r;
  logic [D_WORDS-1:0]  dWordOk_r;

  sdmc_state_t        state_r;
  logic [31:0]        iMissAddr_r;
  logic               iMissCache_r;
  logic               iPend_r;
  logic               iStream_r;
  logic [31:0]        dMissAddr_r;
  logic               dMissCache_r;
  logic               dMissBlock_r;
  logic               fixIsData_r;
  logic [31:0]        fixWord_r;
  logic [1:0]         wCnt_r;
  logic               iValid_r;
  logic [31:0]        iData_r;
  logic               dValid_r;
  logic [31:0]        dRdata_r;

  logic [IIW-1:0]     iIdx;
  logic [1:0]         iOff;
  logic               iHit;
  logic [DIW-1:0]     dIdx;
  logic               dHit;
  logic               dPartial;
  logic               iTake;
  logic               dTake;
  logic               dLoadMiss;
  logic               iMiss;
  logic [DIW-1:0]     dFillIdx;
  logic [1:0]         missOff;
  logic               fillTarget;
  logic [31:0]        merged;
  logic               wbInValid;
  logic               wbInReady;
  logic               wbEmpty;
  sdmc_wbent_t        wbIn;

  // Byte-lane merge of partial store data into a cached word
  function automatic logic [31:0] mergeBytes(input logic [31:0] oldW,
                                             input logic [31:0] newW,
                                             input logic [3:0]  be);
    logic [31:0] res;
    res = oldW;
    for (int b = 0; b < `SDMC_BE_W; b++)
    begin
      if (be[b])
      begin
        res[8*b +: 8] = newW[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Physical address splits: index from low bits, tag from the rest
  assign iIdx = iAddr[`SDMC_LINE_LSB +: IIW];
  assign iOff = iAddr[`SDMC_WORD_LSB +: `SDMC_WOFF_W];
  assign dIdx = dReq.addr[`SDMC_WORD_LSB +: DIW];

  // Data and tag read together; one candidate location only
  assign iHit = iCacheable && iLineOk_r[iIdx]
             && (iTags[iIdx] == iAddr[31 -: ITW]);
  assign dHit = dReq.cacheable && dWordOk_r[dIdx]
             && (dTags[dIdx] == dReq.addr[31 -: DTW]);
  assign dPartial = (dReq.be != `SDMC_BE_FULL);

  // Both requests are taken in the same cycle: the data access uses the
  // first phase address and second phase transfer, the instruction word
  // addressed now completes in the first phase of the next cycle
  assign iTake = iReq && !coreStall;
  assign dTake = dReq.valid && !coreStall;
  assign dLoadMiss = dTake && !dReq.write && !dHit;
  assign iMiss = iTake && !iHit;

  // Stall only on a miss or a full write buffer, so all-hit code runs
  // one access per cycle; stall is combinational to keep that rate
  assign coreStall = (state_r != ST_IDLE)
                  || (dReq.valid && dReq.write && !wbInReady);

  // Merged word for partial store hits
  assign merged = mergeBytes(dMem[dIdx], dReq.wdata, dReq.be);

  // Every store goes to memory; a partial hit is sent as the merged word
  assign wbInValid = dTake && dReq.write;
  always_comb
  begin
    wbIn.addr = dReq.addr;
    if (dPartial && dHit)
    begin
      wbIn.data = merged;
      wbIn.be   = `SDMC_BE_FULL;
    end
    else
    begin
      wbIn.data = dReq.wdata;
      wbIn.be   = dReq.be;
    end
  end

  sdmc_wbuf u_wbuf (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (wbInValid),
    .inEnt    (wbIn),
    .inReady  (wbInReady),
    .outValid (wbValid),
    .outEnt   (wbOut),
    .outReady (wbReady),
    .empty    (wbEmpty)
  );

  // Refill bookkeeping: the data block fill walks four consecutive words
  assign dFillIdx = dMissBlock_r
                  ? {dMissAddr_r[`SDMC_LINE_LSB +: DIW-2], wCnt_r}
                  : dMissAddr_r[`SDMC_WORD_LSB +: DIW];
  assign missOff = (state_r == ST_IREAD)
                 ? iMissAddr_r[`SDMC_WORD_LSB +: 2]
                 : dMissAddr_r[`SDMC_WORD_LSB +: 2];
  assign fillTarget = !memRd.block || (wCnt_r == missOff);

  // Read request: line-aligned block for instruction fills, optional
  // block for data; the bus side may split or burst it as it likes
  always_comb
  begin
    memRd.req   = (state_r == ST_DREAD) || (state_r == ST_IREAD);
    memRd.block = 1'b0;
    memRd.addr  = dMissAddr_r;
    if (state_r == ST_IREAD)
    begin
      memRd.block = iMissCache_r;
      memRd.addr  = iMissCache_r ? {iMissAddr_r[31:4], 4'h0} : iMissAddr_r;
    end
    else if (dMissBlock_r)
    begin
      memRd.block = 1'b1;
      memRd.addr  = {dMissAddr_r[31:4], 4'h0};
    end
  end

  // Instruction storage: refill words land at line index plus word count
  always_ff @(posedge clk)
  begin
    if ((state_r == ST_IREAD) && iMissCache_r && memRdValid)
    begin
      iMem[{iMissAddr_r[`SDMC_LINE_LSB +: IIW], wCnt_r}] <= memRdData;
      iTags[iMissAddr_r[`SDMC_LINE_LSB +: IIW]] <= iMissAddr_r[31 -: ITW];
    end
  end

  // Data storage: stores in the idle state, refill words in the read state
  always_ff @(posedge clk)
  begin
    if ((state_r == ST_IDLE) && dTake && dReq.write && dReq.cacheable
        && (!dPartial || dHit) && wbInReady)
    begin
      dMem[dIdx]  <= dPartial ? merged : dReq.wdata;
      dTags[dIdx] <= dReq.addr[31 -: DTW];
    end
    else if ((state_r == ST_DREAD) && dMissCache_r && memRdValid)
    begin
      dMem[dFillIdx]  <= memRdData;
      dTags[dFillIdx] <= dMissAddr_r[31 -: DTW];
    end
  end

  // Valid bits: cleared by reset; an instruction line is invalid while it refills, data words turn valid as each lands
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      iLineOk_r <= '0;
      dWordOk_r <= '0;
    end
    else
    begin
      if ((state_r == ST_IREAD) && iMissCache_r && memRdValid)
      begin
        iLineOk_r[iMissAddr_r[`SDMC_LINE_LSB +: IIW]] <= memRdLast;
      end
      if ((state_r == ST_IDLE) && dTake && dReq.write && dReq.cacheable
          && !dPartial && wbInReady)
      begin
        dWordOk_r[dIdx] <= 1'b1;
      end
      else if ((state_r == ST_DREAD) && dMissCache_r && memRdValid)
      begin
        dWordOk_r[dFillIdx] <= 1'b1;
      end
    end
  end

  // Miss sequencing; the data miss always goes first
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      iPend_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (dLoadMiss)
          begin
            state_r <= ST_DWAIT;
            iPend_r <= iMiss;
          end
          else if (iMiss)
          begin
            state_r <= ST_IREAD;
          end
        end
        // Older stores must reach memory before the read is issued
        ST_DWAIT:
        begin
          if (wbEmpty)
          begin
            state_r <= ST_DREAD;
          end
        end
        ST_DREAD, ST_IREAD:
        begin
          if (memRdValid && memRdLast)
          begin
            state_r <= ST_FIX;
          end
        end
        ST_FIX:
        begin
          state_r <= iPend_r ? ST_IREAD : ST_IDLE;
          iPend_r <= 1'b0;
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Capture the failing references so the fixup can re-address them
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      iMissAddr_r  <= 32'h0000_0000;
      iMissCache_r <= 1'b0;
      dMissAddr_r  <= 32'h0000_0000;
      dMissCache_r <= 1'b0;
      dMissBlock_r <= 1'b0;
      fixIsData_r  <= 1'b0;
    end
    else if (state_r == ST_IDLE)
    begin
      if (iMiss)
      begin
        iMissAddr_r  <= iAddr;
        iMissCache_r <= iCacheable;
      end
      if (dLoadMiss)
      begin
        dMissAddr_r  <= dReq.addr;
        dMissCache_r <= dReq.cacheable;
        dMissBlock_r <= dReq.cacheable && dBlockRefill;
      end
      fixIsData_r <= dLoadMiss;
    end
    else if (state_r == ST_FIX)
    begin
      fixIsData_r <= 1'b0;
    end
  end

  // Word counter and missed-word capture during refill
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wCnt_r    <= 2'h0;
      fixWord_r <= 32'h0000_0000;
    end
    else if ((state_r == ST_DREAD) || (state_r == ST_IREAD))
    begin
      if (memRdValid)
      begin
        wCnt_r <= memRdLast ? 2'h0 : wCnt_r + 2'h1;
        if (fillTarget)
        begin
          fixWord_r <= memRdData;
        end
      end
    end
    else
    begin
      wCnt_r <= 2'h0;
    end
  end

  // Streaming stays on until the core abandons the block
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      iStream_r <= 1'b0;
    end
    else if ((state_r != ST_IREAD) || (memRdValid && memRdLast))
    begin
      iStream_r <= 1'b1;
    end
    else if (iStreamStop)
    begin
      iStream_r <= 1'b0;
    end
  end

  // Instruction answer: hit word one cycle after addressing, streamed
  // refill words from the missed word on, or the uncached fixup word
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      iValid_r <= 1'b0;
      iData_r  <= 32'h0000_0000;
    end
    else
    begin
      iValid_r <= 1'b0;
      if (iTake && iHit)
      begin
        iValid_r <= 1'b1;
        iData_r  <= iMem[{iIdx, iOff}];
      end
      else if ((state_r == ST_IREAD) && iMissCache_r && memRdValid
               && ((wCnt_r == missOff) || (iStream_r && (wCnt_r > missOff))))
      begin
        iValid_r <= 1'b1;
        iData_r  <= memRdData;
      end
      else if ((state_r == ST_FIX) && !fixIsData_r && !iMissCache_r)
      begin
        iValid_r <= 1'b1;
        iData_r  <= fixWord_r;
      end
    end
  end

  // Data answer: load hits next cycle; misses only in the fixup cycle,
  // so data refill words are never streamed
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dValid_r <= 1'b0;
      dRdata_r <= 32'h0000_0000;
    end
    else
    begin
      dValid_r <= 1'b0;
      if (dTake && !dReq.write && dHit)
      begin
        dValid_r <= 1'b1;
        dRdata_r <= dMem[dIdx];
      end
      else if ((state_r == ST_FIX) && fixIsData_r)
      begin
        dValid_r <= 1'b1;
        dRdata_r <= fixWord_r;
      end
    end
  end

  assign iValid = iValid_r;
  assign iData  = iData_r;
  assign dValid = dValid_r;
  assign dRdata = dRdata_r;

endmodule

// [test/sdmc_cache_props.sv]
// Concurrent checks on the split cache top-level ports.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps

module sdmc_cache_props
  import sdmc_pkg::*;
#(
  parameter int I_LINES = 64,
  parameter int D_WORDS = 512
)(
  // Clock and reset
  input wire logic         clk,
  input wire logic         rst_n,
  // Core side
  input wire logic         iReq,
  input wire logic         iValid,
  input wire sdmc_dreq_t   dReq,
  input wire logic         dValid,
  input wire logic         coreStall,
  // Memory side
  input wire sdmc_rdreq_t  memRd,
  input wire logic         memRdValid,
  input wire logic         memRdLast,
  input wire logic         wbValid,
  input wire sdmc_wbent_t  wbOut,
  input wire logic         wbReady
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Steps of a transfer
  sequence s_fetchTaken; iReq && !coreStall; endsequence
  sequence s_loadTaken; dReq.valid && !dReq.write && !coreStall; endsequence
  sequence s_lastWord; memRdValid && memRdLast; endsequence

  // A taken fetch answers next cycle or the miss stalls the core
  property p_fetchAnswer; s_fetchTaken |=> iValid || coreStall; endproperty
  a_fetchAnswer: assert property (p_fetchAnswer) else $error("fetch neither answered nor stalled");
  property p_loadAnswer; s_loadTaken |=> dValid || coreStall; endproperty
  a_loadAnswer: assert property (p_loadAnswer) else $error("load neither answered nor stalled");
  // Final word is followed by the fixup cycle with the read dropped
  property p_fixup; s_lastWord |=> !memRd.req && coreStall; endproperty
  a_fixup: assert property (p_fixup) else $error("no fixup after last word");
  // Read request holds its address until its last word
  property p_readHold;
    memRd.req && !(memRdValid && memRdLast) |=>
      memRd.req && $stable(memRd.addr) && $stable(memRd.block);
  endproperty
  a_readHold: assert property (p_readHold) else $error("read request moved early");
  property p_storeBuffered; dReq.valid && dReq.write && !coreStall |=> wbValid; endproperty
  a_storeBuffered: assert property (p_storeBuffered) else $error("store not buffered");
  property p_lineAligned; $rose(memRd.req) && memRd.block |-> memRd.addr[3:0] == 4'h0; endproperty
  a_lineAligned: assert property (p_lineAligned) else $error("block read not line aligned");
  property p_missStalls; memRd.req |-> coreStall; endproperty
  a_missStalls: assert property (p_missStalls) else $error("core runs during miss read");
  property p_bufHold; wbValid && !wbReady |=> wbValid && $stable(wbOut); endproperty
  a_bufHold: assert property (p_bufHold) else $error("buffer head changed unpopped");
endmodule

bind sdmc_cache sdmc_cache_props #(.I_LINES(I_LINES), .D_WORDS(D_WORDS)) i_sdmc_cache_props (
  .clk(clk), .rst_n(rst_n), .iReq(iReq), .iValid(iValid), .dReq(dReq), .dValid(dValid),
  .coreStall(coreStall), .memRd(memRd), .memRdValid(memRdValid), .memRdLast(memRdLast),
  .wbValid(wbValid), .wbOut(wbOut), .wbReady(wbReady));

// [test/sdmc_mem_model.sv]
// Behavioural bus interface unit with a 1 KB word memory behind it.
// Assumes the cache holds each read request until the word after its last.
`timescale 1ns/1ps

module sdmc_mem_model
  import sdmc_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Cache side
  input  wire sdmc_rdreq_t  memRd,
  output logic              memRdValid,
  output logic [31:0]       memRdData,
  output logic              memRdLast,
  input  wire logic         wbValid,
  input  wire sdmc_wbent_t  wbOut,
  output logic              wbReady,
  // Pacing from the bench
  input  wire logic         slow,
  input  wire logic         wbStall
);
  logic [31:0] mem [0:255];
  logic        busy, done;
  logic [1:0]  word, gap;

  initial for (int k = 0; k < 256; k++) mem[k] = 32'hC0DE_0000 | (32'(k) << 2);

  // Reads answer per word, idle data toggles so stale values never pass
  always @(posedge clk)
  begin
    memRdValid <= 1'b0;
    memRdLast  <= 1'b0;
    if (!rst_n)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      wbReady <= 1'b0;
      memRdData <= 32'h0F0F_0F0F;
    end
    else
    begin
      wbReady <= !wbStall && !wbReady; // drains at half rate, in order
      if (wbValid && wbReady)
        for (int b = 0; b < 4; b++)
          if (wbOut.be[b]) mem[wbOut.addr[9:2]][8*b+:8] <= wbOut.data[8*b+:8];
      if (!memRd.req) done <= 1'b0;
      if (memRd.req && !busy && !done)
      begin
        busy <= 1'b1;
        word <= 2'h0;
        gap  <= slow ? 2'h3 : 2'h0; // slow protocol or burst
      end
      else if (busy && gap != 2'h0)
      begin
        gap <= gap - 2'h1;
        memRdData <= ~memRdData;
      end
      else if (busy)
      begin
        memRdValid <= 1'b1;
        memRdData  <= mem[{memRd.addr[9:4], memRd.block ? word : memRd.addr[3:2]}];
        memRdLast  <= !memRd.block || word == 2'h3;
        word <= word + 2'h1;
        gap  <= slow ? 2'h2 : 2'h0;
        if (!memRd.block || word == 2'h3)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
      else memRdData <= ~memRdData;
    end
  end
endmodule

// [test/sdmc_cache_bench.sv]
// Self-checking bench: core driver, answer monitors and scenario tasks.
// Assumes the package, checker and memory model are compiled first.
`timescale 1ns/1ps

module sdmc_cache_bench
  import sdmc_pkg::*;
;
  // Stimulus
  logic        clk = 0, rst_n = 0, iReq = 0, iCacheable = 0, iStreamStop = 0;
  logic        dBlockRefill = 0, slow = 0, wbStall = 0, rdPrev = 0;
  logic [31:0] iAddr = 32'h0000_0000;
  sdmc_dreq_t  dReq = '0;
  // Observed
  logic        iValid, dValid, coreStall, memRdValid, memRdLast, wbValid, wbReady;
  logic [31:0] iData, dRdata, memRdData, iq[$], dq[$];
  sdmc_rdreq_t memRd, rq[$];
  sdmc_wbent_t wbOut, wq[$];
  int          num_errors = 0, checks_done = 0;

  always #12.5 clk = ~clk;

  sdmc_cache #(.I_LINES(4), .D_WORDS(16)) i_sdmc_cache (
    .clk(clk), .rst_n(rst_n), .iReq(iReq), .iAddr(iAddr), .iCacheable(iCacheable),
    .iStreamStop(iStreamStop), .iValid(iValid), .iData(iData), .dReq(dReq), .dValid(dValid),
    .dRdata(dRdata), .coreStall(coreStall), .dBlockRefill(dBlockRefill), .memRd(memRd),
    .memRdValid(memRdValid), .memRdData(memRdData), .memRdLast(memRdLast),
    .wbValid(wbValid), .wbOut(wbOut), .wbReady(wbReady));
  sdmc_mem_model i_sdmc_mem_model (
    .clk(clk), .rst_n(rst_n), .memRd(memRd), .memRdValid(memRdValid), .memRdData(memRdData),
    .memRdLast(memRdLast), .wbValid(wbValid), .wbOut(wbOut), .wbReady(wbReady),
    .slow(slow), .wbStall(wbStall));

  // Collect answers, pops and new reads; values are pre-edge so no race
  always @(posedge clk)
  begin
    if (iValid === 1'b1) iq.push_back(iData);
    if (dValid === 1'b1) dq.push_back(dRdata);
    if (wbValid === 1'b1 && wbReady === 1'b1) wq.push_back(wbOut);
    if (memRd.req === 1'b1 && !rdPrev) rq.push_back(memRd);
    rdPrev <= memRd.req === 1'b1;
  end

  function automatic logic [31:0] pat(input logic [31:0] a);
    return 32'hC0DE_0000 | {22'h0, a[9:2], 2'b00};
  endfunction
  function automatic sdmc_dreq_t dr(input logic w, c, input logic [3:0] b,
                                    input logic [31:0] a, d);
    return {1'b1, w, c, b, a, d};
  endfunction

  task automatic ck(input logic [67:0] got, input logic [67:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pq(ref logic [31:0] q[$], input logic [31:0] exp);
    logic [31:0] v;
    v = 'x;
    if (q.size() > 0) v = q.pop_front();
    ck(68'(v), 68'(exp));
  endtask
  task automatic pw(input logic [31:0] a, d, input logic [3:0] b);
    sdmc_wbent_t e;
    e = 'x;
    if (wq.size() > 0) e = wq.pop_front();
    ck(e, {a, d, b});
  endtask

  // Present a request and hold it until the edge that takes it
  task automatic go(input logic iv, input logic [31:0] ia, input logic ic, input sdmc_dreq_t d);
    int n;
    n = 0;
    iReq = iv;
    iAddr = ia;
    iCacheable = ic;
    dReq = d;
    #1;
    while (coreStall !== 1'b0 && n < 400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    ck(68'(n >= 400), 68'h0);
    @(posedge clk);
    #1;
  endtask
  // Drop requests and wait for misses and stores to finish
  task automatic quiet();
    int n;
    n = 0;
    iReq = 0;
    dReq = '0;
    repeat (3) @(posedge clk);
    while ((coreStall !== 1'b0 || memRd.req !== 1'b0 || wbValid !== 1'b0) && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    ck(68'(n >= 400), 68'h0);
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic t_ifetch();
    slow = 1;
    go(1, 32'h0000_0108, 1, '0);
    quiet();
    pq(iq, pat(32'h0000_0108));
    pq(iq, pat(32'h0000_010C));
    ck(68'(rq[0].addr), 68'h100);
    go(1, 32'h0000_0100, 1, '0);
    go(1, 32'h0000_0104, 1, '0);
    quiet();
    pq(iq, pat(32'h0000_0100));
    pq(iq, pat(32'h0000_0104));
    iStreamStop = 1;
    go(1, 32'h0000_0140, 1, '0);
    quiet();
    iStreamStop = 0;
    go(1, 32'h0000_0144, 1, '0);
    quiet();
    pq(iq, pat(32'h0000_0140));
    pq(iq, pat(32'h0000_0144));
    go(1, 32'h0000_0104, 1, '0);
    quiet();
    for (int k = 1; k < 4; k++) pq(iq, pat(32'h0000_0100 + 4 * k));
    ck(68'(rq.size()), 68'h3);
    ck(68'(iq.size()), 68'h0);
    slow = 0;
    $display("instruction fetch test done");
  endtask

  task automatic t_uncached();
    rq.delete();
    go(1, 32'h0000_0200, 0, '0);
    go(1, 32'h0000_0200, 0, '0);
    quiet();
    pq(iq, pat(32'h0000_0200));
    pq(iq, pat(32'h0000_0200));
    ck(68'({rq.size(), rq[0].block}), 68'h4);
    $display("uncached fetch test done");
  endtask

  task automatic t_dstore();
    logic [31:0] m;
    m = (pat(32'h0000_0300) & 32'hFFFF_FF00) | 32'h0000_00AB;
    rq.delete();
    go(0, 0, 0, dr(0, 1, 4'hF, 32'h0000_0300, 0));
    go(0, 0, 0, dr(0, 1, 4'hF, 32'h0000_0300, 0));
    go(0, 0, 0, dr(1, 1, 4'h1, 32'h0000_0300, 32'h0000_00AB));
    go(0, 0, 0, dr(0, 1, 4'hF, 32'h0000_0300, 0));
    quiet();
    pq(dq, pat(32'h0000_0300));
    pq(dq, pat(32'h0000_0300));
    pw(32'h0000_0300, m, 4'hF);
    pq(dq, m);
    go(0, 0, 0, dr(1, 1, 4'h2, 32'h0000_0304, 32'h0000_CD00));
    go(0, 0, 0, dr(0, 1, 4'hF, 32'h0000_0304, 0));
    quiet();
    pw(32'h0000_0304, 32'h0000_CD00, 4'h2);
    pq(dq, pat(32'h0000_0304) & 32'hFFFF_00FF | 32'h0000_CD00);
    go(0, 0, 0, dr(1, 0, 4'hF, 32'h0000_0308, 32'h1234_5678));
    go(0, 0, 0, dr(1, 1, 4'hF, 32'h0000_030C, 32'h9ABC_DEF0));
    go(0, 0, 0, dr(0, 1, 4'hF, 32'h0000_030C, 0));
    go(0, 0, 0, dr(0, 1, 4'hF, 32'h0000_0308, 0));
    quiet();
    pw(32'h0000_0308, 32'h1234_5678, 4'hF);
    pw(32'h0000_030C, 32'h9ABC_DEF0, 4'hF);
    pq(dq, 32'h9ABC_DEF0);
    pq(dq, 32'h1234_5678);
    ck(68'(rq.size()), 68'h3);
    $display("data store test done");
  endtask

  task automatic t_wbfull();
    wbStall = 1;
    for (int k = 0; k < 4; k++) go(0, 0, 0, dr(1, 0, 4'hF, 32'h0000_0310 + 4 * k, k));
    dReq = dr(1, 0, 4'hF, 32'h0000_0320, 4);
    #1;
    ck(68'(coreStall), 68'h1);
    @(posedge clk);
    #1;
    wbStall = 0;
    go(0, 0, 0, dr(1, 0, 4'hF, 32'h0000_0320, 4));
    quiet();
    for (int k = 0; k < 5; k++) pw(32'h0000_0310 + 4 * k, k, 4'hF);
    // Uncached load must not allocate: the first cached load misses, the next hits
    rq.delete();
    for (int k = 0; k < 3; k++) go(0, 0, 0, dr(0, k > 0, 4'hF, 32'h0000_0314, 0));
    quiet();
    for (int k = 0; k < 3; k++) pq(dq, 32'h0000_0001);
    ck(68'(rq.size()), 68'h2);
    $display("write buffer test done");
  endtask

  task automatic t_both();
    rq.delete();
    go(1, 32'h0000_0180, 1, dr(0, 1, 4'hF, 32'h0000_0340, 0));
    quiet();
    ck(68'(rq[0].addr), 68'h340);
    ck(68'(rq[1].addr), 68'h180);
    pq(dq, pat(32'h0000_0340));
    for (int k = 0; k < 4; k++) pq(iq, pat(32'h0000_0180 + 4 * k));
    $display("dual miss test done");
  endtask

  task automatic t_dblock();
    dBlockRefill = 1;
    rq.delete();
    go(0, 0, 0, dr(0, 1, 4'hF, 32'h0000_0384, 0));
    for (int k = 0; k < 4; k += 2) go(0, 0, 0, dr(0, 1, 4'hF, 32'h0000_0380 + 4 * k, 0));
    go(0, 0, 0, dr(0, 1, 4'hF, 32'h0000_038C, 0));
    quiet();
    ck(68'({rq.size(), rq[0].block, rq[0].addr}), 68'h3_0000_0380);
    pq(dq, pat(32'h0000_0384));
    pq(dq, pat(32'h0000_0380));
    pq(dq, pat(32'h0000_0388));
    pq(dq, pat(32'h0000_038C));
    ck(68'(dq.size()), 68'h0);
    dBlockRefill = 0;
    $display("data block refill test done");
  endtask

  task end_sim();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1;
    @(posedge clk);
    #1;
    t_ifetch();
    t_uncached();
    t_dstore();
    t_wbfull();
    t_both();
    t_dblock();
    end_sim();
  end

  // Watchdog well past the few hundred cycles the tests need
  initial
  begin
    #500000;
    num_errors++;
    end_sim();
  end
endmodule
